// ===== inc/reload_timer_pkg.sv
// register map, field positions and timing constants of the dual mode reload timer
// assumes an 8-bit special-function register port inside the owning core
package reload_timer_pkg;

  // register offsets
  localparam logic [7:0] control_offset     = 8'h91;
  localparam logic [7:0] reload_low_offset  = 8'h92;
  localparam logic [7:0] reload_high_offset = 8'h93;
  localparam logic [7:0] count_low_offset   = 8'h94;
  localparam logic [7:0] count_high_offset  = 8'h95;

  // control register fields
  localparam int high_overflow_bit      = 7;
  localparam int low_overflow_bit       = 6;
  localparam int low_irq_enable_bit     = 5;
  localparam int capture_enable_bit     = 4;
  localparam int split_mode_bit         = 3;
  localparam int run_control_bit        = 2;
  localparam int unused_bit             = 1;
  localparam int external_clock_bit     = 0;

  // reset values and the all-ones wrap value
  localparam logic [7:0] control_reset = 8'h00;
  localparam logic [7:0] byte_reset    = 8'h00;
  localparam logic [7:0] byte_all_ones = 8'hff;

  // prescaler counts
  localparam int          system_clock_divide   = 12;
  localparam logic [3:0]  div12_last      = 4'(system_clock_divide - 1);
  localparam int          external_divide = 8;
  localparam logic [2:0]  div8_last       = 3'(external_divide - 1);

  // register port carrier
  typedef struct packed {
    logic       write;
    logic       read;
    logic [7:0] address;
    logic [7:0] data;
  } reg_request_type;

  // clock sources after selection
  typedef enum logic [1:0] {
    source_system_clock = 2'b00,
    source_div12  = 2'b01,
    source_ext8   = 2'b10
  } source_type;

endpackage

// ===== hw/dual_mode_reload_timer.sv
// dual mode auto-reload timer: one 16-bit or two 8-bit counters, reload, capture
// assumes all register accesses and the interrupt enable come from the system clock domain;
// external oscillator and low-frequency oscillator arrive asynchronously
`timescale 1ns/10ps
`default_nettype none

module dual_mode_reload_timer (
  // clock and reset
  input  wire logic                             clock,
  input  wire logic                             arst_n,
  // register port
  input  wire reload_timer_pkg::reg_request_type reg_request,
  output logic      [7:0]                       read_data,
  // clock select bits held in the clock control register
  input  wire logic                             high_byte_clock_select,
  input  wire logic                             low_byte_clock_select,
  // timer interrupt enable from the interrupt controller
  input  wire logic                             timer_irq_enable,
  // asynchronous clock sources
  input  wire logic                             external_oscillator,
  input  wire logic                             lfo_output,
  // interrupt request
  output logic                                  irq_request
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release
  logic [1:0] reset_sync;
  logic       rst_n;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      reset_sync <= 2'b00;
    end else begin
      reset_sync <= {reset_sync[0], 1'b1};
    end
  end
  assign rst_n = reset_sync[1];

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers, change counts once stages two and three agree
  logic [2:0] ext_sync;
  logic [2:0] lfo_sync;
  logic       ext_level;
  logic       lfo_level;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ext_sync  <= 3'h0;
      lfo_sync  <= 3'h0;
      ext_level <= 1'b0;
      lfo_level <= 1'b0;
    end else begin
      ext_sync <= {ext_sync[1:0], external_oscillator};
      lfo_sync <= {lfo_sync[1:0], lfo_output};
      if (ext_sync[1] == ext_sync[2]) begin
        ext_level <= ext_sync[2];
      end
      if (lfo_sync[1] == lfo_sync[2]) begin
        lfo_level <= lfo_sync[2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // prescalers as one-cycle enables
  logic [3:0] div12_count;
  logic [2:0] div8_count;
  logic       ext_level_d;
  logic       lfo_level_d;
  logic       tick_div12;
  logic       tick_ext8;
  logic       lfo_rise;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div12_count <= 4'h0;
    end else if (div12_count == reload_timer_pkg::div12_last) begin
      div12_count <= 4'h0;
    end else begin
      div12_count <= div12_count + 4'h1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ext_level_d <= 1'b0;
      div8_count  <= 3'h0;
    end else begin
      ext_level_d <= ext_level;
      if (ext_level && !ext_level_d) begin
        div8_count <= div8_count + 3'h1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lfo_level_d <= 1'b0;
    end else begin
      lfo_level_d <= lfo_level;
    end
  end

  assign tick_div12 = (div12_count == reload_timer_pkg::div12_last);
  assign tick_ext8  = ext_level && !ext_level_d
                      && (div8_count == reload_timer_pkg::div8_last);
  assign lfo_rise   = lfo_level && !lfo_level_d;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] reload_low_byte;
  logic [7:0] reload_high_byte;
  logic [7:0] low_counter;
  logic [7:0] high_counter;
  logic       high_overflow_flag;
  logic       low_overflow_flag;
  logic       low_byte_irq_enable;
  logic       lfo_capture_enable;
  logic       split_mode_select;
  logic       run_control;
  logic       external_clock_select;

  logic write_control;
  logic write_reload_low;
  logic write_reload_high;
  logic write_count_low;
  logic write_count_high;

  assign write_control     = reg_request.write
                             && reg_request.address == reload_timer_pkg::control_offset;
  assign write_reload_low  = reg_request.write
                             && reg_request.address == reload_timer_pkg::reload_low_offset;
  assign write_reload_high = reg_request.write
                             && reg_request.address == reload_timer_pkg::reload_high_offset;
  assign write_count_low   = reg_request.write
                             && reg_request.address == reload_timer_pkg::count_low_offset;
  assign write_count_high  = reg_request.write
                             && reg_request.address == reload_timer_pkg::count_high_offset;

  ////////////////////////////////////////////////////////////////////////////
  // count enables
  logic tick_low;
  logic tick_high;
  logic low_wrap;
  logic high_wrap;
  logic run_low;
  logic run_high;
  logic capture;

  // one byte clock: system_clock when its select is set, else div12 or ext/8
  function automatic logic pick_tick(input logic byte_select, input logic ext_select,
                                     input logic t12, input logic t8);
    logic result;
    result = 1'b1;
    if (!byte_select) begin
      result = ext_select ? t8 : t12;
    end
    return result;
  endfunction

  assign tick_low  = pick_tick(low_byte_clock_select, external_clock_select,
                               tick_div12, tick_ext8);
  assign tick_high = split_mode_select
                     ? pick_tick(high_byte_clock_select, external_clock_select,
                                 tick_div12, tick_ext8)
                     : tick_low;
  // low runs always in split mode; high gated by run bit in both modes
  assign run_low   = tick_low && (split_mode_select || run_control);
  assign run_high  = tick_high && run_control;
  assign low_wrap  = run_low && low_counter == reload_timer_pkg::byte_all_ones;
  // 16-bit: high wraps on carry out of the low byte
  assign high_wrap = split_mode_select
                     ? run_high && high_counter == reload_timer_pkg::byte_all_ones
                     : low_wrap && high_counter == reload_timer_pkg::byte_all_ones;
  assign capture   = lfo_capture_enable && timer_irq_enable && lfo_rise;

  ////////////////////////////////////////////////////////////////////////////
  // counters, software write takes priority over counting
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      low_counter  <= reload_timer_pkg::byte_reset;
      high_counter <= reload_timer_pkg::byte_reset;
    end else begin
      if (write_count_low) begin
        low_counter <= reg_request.data;
      end else if (split_mode_select && low_wrap) begin
        low_counter <= reload_low_byte;
      end else if (!split_mode_select && high_wrap) begin
        low_counter <= reload_low_byte;
      end else if (run_low) begin
        low_counter <= low_counter + 8'h01;
      end
      if (write_count_high) begin
        high_counter <= reg_request.data;
      end else if (high_wrap) begin
        high_counter <= reload_high_byte;
      end else if (split_mode_select ? run_high : low_wrap) begin
        high_counter <= high_counter + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reload registers, capture loads the count
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reload_low_byte  <= reload_timer_pkg::byte_reset;
      reload_high_byte <= reload_timer_pkg::byte_reset;
    end else if (capture) begin
      reload_low_byte  <= low_counter;
      reload_high_byte <= high_counter;
    end else begin
      if (write_reload_low) begin
        reload_low_byte <= reg_request.data;
      end
      if (write_reload_high) begin
        reload_high_byte <= reg_request.data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register, hardware set wins over software clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      high_overflow_flag    <= 1'b0;
      low_overflow_flag     <= 1'b0;
      low_byte_irq_enable   <= 1'b0;
      lfo_capture_enable    <= 1'b0;
      split_mode_select     <= 1'b0;
      run_control           <= 1'b0;
      external_clock_select <= 1'b0;
    end else begin
      if (write_control) begin
        high_overflow_flag    <= reg_request.data[reload_timer_pkg::high_overflow_bit];
        low_overflow_flag     <= reg_request.data[reload_timer_pkg::low_overflow_bit];
        low_byte_irq_enable   <= reg_request.data[reload_timer_pkg::low_irq_enable_bit];
        lfo_capture_enable    <= reg_request.data[reload_timer_pkg::capture_enable_bit];
        split_mode_select     <= reg_request.data[reload_timer_pkg::split_mode_bit];
        run_control           <= reg_request.data[reload_timer_pkg::run_control_bit];
        external_clock_select <= reg_request.data[reload_timer_pkg::external_clock_bit];
      end
      if (high_wrap) begin
        high_overflow_flag <= 1'b1;
      end
      if (low_wrap) begin
        low_overflow_flag <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt request and read data
  logic [7:0] control_value;
  logic [7:0] next_read_data;

  always_comb begin
    control_value = reload_timer_pkg::control_reset;
    control_value[reload_timer_pkg::high_overflow_bit]  = high_overflow_flag;
    control_value[reload_timer_pkg::low_overflow_bit]   = low_overflow_flag;
    control_value[reload_timer_pkg::low_irq_enable_bit] = low_byte_irq_enable;
    control_value[reload_timer_pkg::capture_enable_bit] = lfo_capture_enable;
    control_value[reload_timer_pkg::split_mode_bit]     = split_mode_select;
    control_value[reload_timer_pkg::run_control_bit]    = run_control;
    control_value[reload_timer_pkg::unused_bit]         = 1'b0;
    control_value[reload_timer_pkg::external_clock_bit] = external_clock_select;
  end

  always_comb begin
    case (reg_request.address)
      reload_timer_pkg::control_offset:     next_read_data = control_value;
      reload_timer_pkg::reload_low_offset:  next_read_data = reload_low_byte;
      reload_timer_pkg::reload_high_offset: next_read_data = reload_high_byte;
      reload_timer_pkg::count_low_offset:   next_read_data = low_counter;
      reload_timer_pkg::count_high_offset:  next_read_data = high_counter;
      default:                              next_read_data = 8'h00;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      read_data <= 8'h00;
    end else if (reg_request.read) begin
      read_data <= next_read_data;
    end
  end

  // request pulses one cycle per event; flags keep the level for software
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_request <= 1'b0;
    end else begin
      irq_request <= timer_irq_enable
                     && (high_wrap
                         || (low_byte_irq_enable && low_wrap)
                         || capture);
    end
  end

endmodule
`default_nettype wire

// ===== tb/reload_timer_props.sv
// assertions on the register port and interrupt output of the reload timer
// assumes binding to dual_mode_reload_timer, one clock domain
`timescale 1ns/10ps
`default_nettype none
module reload_timer_props (
  // clock and reset
  input wire logic                              clock,
  input wire logic                              arst_n,
  // register port, interrupt enable and outputs
  input wire reload_timer_pkg::reg_request_type reg_request,
  input wire logic [7:0]                        read_data,
  input wire logic                              timer_irq_enable,
  input wire logic                              irq_request
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  logic rd_ctl;
  logic mapped;
  assign rd_ctl = reg_request.read && reg_request.address == reload_timer_pkg::control_offset;
  assign mapped = reg_request.address >= reload_timer_pkg::control_offset
               && reg_request.address <= reload_timer_pkg::count_high_offset;
  ////////////////////////////////////////////////////////////////////////////////
  sequence put_then_get(logic [7:0] a);
    reg_request.write && reg_request.address == a ##1 !reg_request.write
      ##1 reg_request.read && !reg_request.write && reg_request.address == a;
  endsequence
  sequence two_control_reads;
    rd_ctl && !reg_request.write ##1 !reg_request.write ##1 rd_ctl && !reg_request.write;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  a_bit_one_zero: assert property (rd_ctl |=> !read_data[1])
    else $error("control bit one read back set");
  a_unmapped_zero: assert property (reg_request.read && !mapped |=> read_data == 8'h00)
    else $error("unmapped read not zero");
  a_answer_holds: assert property (!reg_request.read |=> $stable(read_data))
    else $error("read answer changed without a read");
  a_irq_enabled: assert property (irq_request |-> $past(timer_irq_enable))
    else $error("interrupt while disabled");
  a_control_echo: assert property (put_then_get(reload_timer_pkg::control_offset)
    |=> (read_data & 8'h3d) == ($past(reg_request.data, 3) & 8'h3d))
    else $error("control bits not kept");
  a_reload_low_echo: assert property (put_then_get(reload_timer_pkg::reload_low_offset)
    |=> read_data == $past(reg_request.data, 3))
    else $error("reload low not kept");
  a_reload_high_echo: assert property (put_then_get(reload_timer_pkg::reload_high_offset)
    |=> read_data == $past(reg_request.data, 3))
    else $error("reload high not kept");
  a_flags_sticky: assert property (two_control_reads
    |=> (read_data[7:6] & $past(read_data[7:6])) == $past(read_data[7:6]))
    else $error("overflow flag cleared by itself");
endmodule
bind dual_mode_reload_timer reload_timer_props u_props (
  .clock(clock), .arst_n(arst_n), .reg_request(reg_request), .read_data(read_data),
  .timer_irq_enable(timer_irq_enable), .irq_request(irq_request));
`default_nettype wire

// ===== tb/testbench.sv
// self-checking bench for the dual mode reload timer
// assumes the design package and the bound checker are compiled first
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam logic [7:0] ctl = reload_timer_pkg::control_offset;
  localparam logic [7:0] rll = reload_timer_pkg::reload_low_offset;
  localparam logic [7:0] rlh = reload_timer_pkg::reload_high_offset;
  localparam logic [7:0] cl  = reload_timer_pkg::count_low_offset;
  localparam logic [7:0] ch  = reload_timer_pkg::count_high_offset;
  logic                              clock;
  logic                              arst_n;
  reload_timer_pkg::reg_request_type req;
  logic [7:0]                        read_data;
  logic                              hsel;
  logic                              lsel;
  logic                              irq_en;
  logic                              ext_osc = 1'b0;
  logic                              lfo;
  logic                              irq;
  logic [2:0]                        tick = 3'h0;
  int                                err_count;
  int                                cmp_count;
  dual_mode_reload_timer u_dut (
    .clock(clock), .arst_n(arst_n), .reg_request(req), .read_data(read_data),
    .high_byte_clock_select(hsel), .low_byte_clock_select(lsel),
    .timer_irq_enable(irq_en), .external_oscillator(ext_osc), .lfo_output(lfo),
    .irq_request(irq));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // external oscillator at one eighth of the system clock
  always @(posedge clock) begin
    tick <= tick + 3'h1;
    ext_osc <= tick[2];
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] expected);
    cmp_count++;
    if (seen !== expected) begin
      err_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, expected);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge clock);
    req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clock);
    req <= '0;
    #1 d = read_data;
  endtask
  task automatic irq_within(input int n, input logic expected);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(posedge clock);
      #1 if (irq === 1'b1) seen = 1'b1;
    end
    check({7'h00, seen}, {7'h00, expected});
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    end_of_test();
  end
  initial begin
    logic [7:0] v;
    req = '0;
    arst_n = 1'b0;
    hsel = 1'b1;
    lsel = 1'b1;
    irq_en = 1'b1;
    lfo = 1'b0;
    err_count = 0;
    cmp_count = 0;
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    for (int a = 8'h91; a <= 8'h95; a++) begin
      rd(8'(a), v);
      check(v, 8'h00);
    end
    rd(8'h90, v);
    check(v, 8'h00);
    for (int a = 8'h92; a <= 8'h95; a++) begin
      wr(8'(a), 8'(a) ^ 8'h5a);
      rd(8'(a), v);
      check(v, 8'(a) ^ 8'h5a);
    end
    wr(ctl, 8'h02);
    rd(ctl, v);
    check(v, 8'h00);
    wr(ctl, 8'hc0);
    wr(ctl, 8'h00);
    rd(ctl, v);
    check(v, 8'h00);
    // 16-bit overflow with reload
    wr(rll, 8'h34);
    wr(rlh, 8'h12);
    wr(cl, 8'hf0);
    wr(ch, 8'hff);
    wr(ctl, 8'h04);
    irq_within(30, 1'b1);
    rd(ctl, v);
    check(v, 8'hc4);
    wr(ctl, 8'hc0);
    rd(ch, v);
    check(v, 8'h12);
    rd(ctl, v);
    rd(ctl, v);
    check(v, 8'hc0);
    // low byte wrap alone, then with its enable
    wr(ctl, 8'h00);
    wr(ch, 8'h00);
    wr(cl, 8'hf0);
    wr(ctl, 8'h04);
    irq_within(40, 1'b0);
    rd(ctl, v);
    check(v, 8'h44);
    wr(ctl, 8'h00);
    wr(cl, 8'hf0);
    wr(ctl, 8'h24);
    irq_within(40, 1'b1);
    // split mode
    wr(ctl, 8'h00);
    wr(rll, 8'h80);
    wr(cl, 8'hf0);
    wr(ch, 8'hf0);
    wr(ctl, 8'h08);
    irq_within(40, 1'b0);
    rd(ch, v);
    check(v, 8'hf0);
    rd(cl, v);
    check(v & 8'h80, 8'h80);
    rd(ctl, v);
    check(v, 8'h48);
    wr(ctl, 8'h0c);
    irq_within(40, 1'b1);
    rd(ctl, v);
    check(v & 8'h80, 8'h80);
    wr(ctl, 8'h28);
    irq_within(140, 1'b1);
    // prescaled sources in 16-bit mode
    @(posedge clock);
    lsel <= 1'b0;
    wr(ctl, 8'h00);
    wr(cl, 8'h00);
    wr(ch, 8'h00);
    wr(ctl, 8'h04);
    repeat (120) @(posedge clock);
    wr(ctl, 8'h00);
    rd(cl, v);
    check({7'h00, v >= 8'h09 && v <= 8'h0b}, 8'h01);
    wr(cl, 8'h00);
    wr(ctl, 8'h05);
    repeat (500) @(posedge clock);
    wr(ctl, 8'h01);
    rd(cl, v);
    check({7'h00, v >= 8'h06 && v <= 8'h09}, 8'h01);
    // high byte on the divided clock in split mode
    @(posedge clock);
    hsel <= 1'b0;
    wr(ctl, 8'h00);
    wr(ch, 8'h00);
    wr(ctl, 8'h0c);
    repeat (120) @(posedge clock);
    wr(ctl, 8'h08);
    rd(ch, v);
    check({7'h00, v >= 8'h09 && v <= 8'h0b}, 8'h01);
    // capture on the oscillator rising edge
    @(posedge clock);
    lsel <= 1'b1;
    wr(ctl, 8'h00);
    wr(ch, 8'h56);
    wr(cl, 8'h00);
    wr(ctl, 8'h14);
    @(posedge clock);
    lfo <= 1'b1;
    irq_within(20, 1'b1);
    wr(ctl, 8'h00);
    rd(rlh, v);
    check(v, 8'h56);
    // interrupt enable low: flags still set, no request
    @(posedge clock);
    irq_en <= 1'b0;
    wr(cl, 8'hf0);
    wr(ch, 8'hff);
    wr(ctl, 8'h24);
    irq_within(40, 1'b0);
    rd(ctl, v);
    check(v, 8'he4);
    // second reset in mid-run clears loaded and counted values
    @(posedge clock);
    arst_n <= 1'b0;
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    rd(rlh, v);
    check(v, 8'h00);
    rd(cl, v);
    check(v, 8'h00);
    end_of_test();
  end
endmodule
`default_nettype wire
